// [core/slcm_pkg.sv]
// Constants and types shared by the serial link connection manager
package slcm_pkg;

   // Upper-layer request opcodes
   localparam logic [1:0] SLCM_OP_CONNECT = 2'h0;
   localparam logic [1:0] SLCM_OP_LISTEN  = 2'h1;
   localparam logic [1:0] SLCM_OP_RECEIVE = 2'h2;
   localparam logic [1:0] SLCM_OP_CLOSE   = 2'h3;

   // Request answer codes
   localparam logic [2:0] SLCM_RSP_GOOD          = 3'h0;
   localparam logic [2:0] SLCM_RSP_INVALID_CONN  = 3'h1;
   localparam logic [2:0] SLCM_RSP_PORT_IN_USE   = 3'h2;
   localparam logic [2:0] SLCM_RSP_RECV_PENDING  = 3'h3;

   // Values after reset
   localparam int         SLCM_CONN_ID_RST   = 0;
   localparam int         SLCM_PORT_SEL_RST  = 0;

   // Connection state
   typedef enum logic [2:0] {
      SLCM_IDLE    = 3'b001,
      SLCM_OPEN    = 3'b010,
      SLCM_CLOSING = 3'b100
   } slcm_state_e;

endpackage : slcm_pkg

// [core/slcm_rx_fifo.sv]
// Store for characters received from the link and not yet passed upward
`timescale 1ns/10ps
module slcm_rx_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic         i_flush,
   input  wire logic         i_wr_en,
   input  wire logic [W-1:0] i_wr_data,
   input  wire logic         i_rd_en,
   output logic      [W-1:0] o_rd_data,
   output logic              o_empty,
   output logic              o_full
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
   logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
   logic [AW:0]   cnt_reg, cnt_next;
   logic          do_wr;
   logic          do_rd;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
         $error("slcm_rx_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   always_comb begin
      do_wr       = i_wr_en && !o_full;
      do_rd       = i_rd_en && !o_empty;
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      cnt_next    = cnt_reg;
      if (i_flush) begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         cnt_next    = '0;
      end else begin
         if (do_wr) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_next = rd_ptr_reg + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_next = cnt_reg + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_next = cnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg    <= cnt_next;
      end
   end

   // Storage array carries no reset; only pointers define contents
   always_ff @(posedge i_clk) begin
      if (do_wr && !i_flush) begin
         mem_reg[wr_ptr_reg] <= i_wr_data;
      end
   end

   assign o_rd_data = mem_reg[rd_ptr_reg];
   assign o_empty   = (cnt_reg == '0);
   assign o_full    = (cnt_reg == DEPTH[AW:0]);

endmodule // slcm_rx_fifo

// [core/slcm_top.sv]
// Connection manager between the port protocol logic and one serial link
//
// What this block does
// - Connect or listen request establishes the connection at once, no peer handshake.
// - Connect or listen puts nothing on the serial link.
// - Connect or listen raises connected with the identifier, possibly before returning.
// - Only one connection is ever tracked.
// - Connect or listen while connected is refused with local-port-busy.
// - Local port selects the physical port, remote port ignored, identifier assigned and reused.
// - Receive never places more characters than its given maximum.
// - Received returns the last receive buffer and the count placed in it.
// - After a good close every accepted send character still goes out.
// - Characters arriving after close may be discarded.
// - During close, receives keep working until earlier characters are all delivered.
// - Closed is raised once everything received has been delivered.
// - Close and closed carry the identifier given by connected.
// - A received reset is handled as port logout either way; hard reset is only flagged on Reset-hard.
// - Reset-received names the drive port on which the reset arrived.
// - Second receive before received is refused with receive-pending.
// - No received after closed until a new connected.
// - Closed delivers a close event to the port state machine.
`timescale 1ns/10ps
module slcm_top
   import slcm_pkg::*;
#(
   parameter int NPORT = 2,
   parameter int IDW   = 4,
   parameter int BW    = 8,
   parameter int CW    = 8,
   parameter int DEPTH = 16,
   parameter int PW    = (NPORT > 1) ? $clog2(NPORT) : 1
) (
   input  wire logic             I_REF_CLK,
   input  wire logic             I_SRST,
   // Request port
   input  wire logic             I_REQ_VALID,
   input  wire logic [1:0]       I_REQ_OP,
   input  wire logic [IDW-1:0]   I_REQ_CONN,
   input  wire logic [PW-1:0]    I_REQ_PORT,
   input  wire logic [BW-1:0]    I_REQ_BUF,
   input  wire logic [CW-1:0]    I_REQ_MAX,
   output logic                  O_RSP_VALID,
   output logic      [2:0]       O_RSP_STATUS,
   output logic      [IDW-1:0]   O_RSP_CONN,
   // Indications
   output logic                  O_CONNECTED,
   output logic      [IDW-1:0]   O_IND_CONN,
   output logic                  O_CLOSED,
   output logic                  O_RECEIVED,
   output logic      [BW-1:0]    O_RECVD_BUF,
   output logic      [CW-1:0]    O_RECVD_COUNT,
   output logic                  O_RD_VALID,
   output logic      [7:0]       O_RD_DATA,
   output logic      [CW-1:0]    O_RD_INDEX,
   // Send stream
   input  wire logic             I_SEND_VALID,
   input  wire logic [7:0]       I_SEND_DATA,
   output logic                  O_SEND_READY,
   // Serial link side
   output logic      [PW-1:0]    O_PORT_SEL,
   output logic                  O_TX_VALID,
   output logic      [7:0]       O_TX_DATA,
   input  wire logic             I_TX_READY,
   input  wire logic             I_RX_VALID,
   input  wire logic [7:0]       I_RX_DATA,
   output logic                  O_RX_READY,
   // Link reset
   input  wire logic [NPORT-1:0] I_LINK_RESET,
   input  wire logic             I_RESET_AS_HARD,
   output logic                  O_RESET_RCVD,
   output logic      [PW-1:0]    O_RESET_PORT,
   output logic                  O_RESET_HARD
);

   generate
      if (NPORT < 1 || IDW < 1 || BW < 1 || CW < 1) begin : g_chk
         $error("slcm_top: NPORT, IDW, BW and CW must be at least 1");
      end
   endgenerate

   slcm_state_e    state_reg, state_next;
   logic [IDW-1:0] conn_id_reg, conn_id_next;
   logic [PW-1:0]  port_sel_reg, port_sel_next;
   logic           rsp_valid_reg, rsp_valid_next;
   logic [2:0]     rsp_status_reg, rsp_status_next;
   logic [IDW-1:0] rsp_conn_reg, rsp_conn_next;
   logic           connected_reg, connected_next;
   logic           closed_reg, closed_next;
   logic           pend_reg, pend_next;
   logic [BW-1:0]  buf_reg, buf_next;
   logic [CW-1:0]  max_reg, max_next;
   logic [CW-1:0]  cnt_reg, cnt_next;
   logic           received_reg, received_next;
   logic [BW-1:0]  recvd_buf_reg, recvd_buf_next;
   logic [CW-1:0]  recvd_cnt_reg, recvd_cnt_next;
   logic           rd_valid_reg, rd_valid_next;
   logic [7:0]     rd_data_reg, rd_data_next;
   logic [CW-1:0]  rd_index_reg, rd_index_next;
   logic           tx_valid_reg, tx_valid_next;
   logic [7:0]     tx_data_reg, tx_data_next;
   logic           rst_rcvd_reg, rst_rcvd_next;
   logic [PW-1:0]  rst_port_reg, rst_port_next;
   logic           rst_hard_reg, rst_hard_next;

   logic           link_reset;
   logic [PW-1:0]  link_reset_port;
   logic           fifo_empty;
   logic           fifo_full;
   logic [7:0]     fifo_data;
   logic           fifo_wr;
   logic           fifo_rd;
   logic           fifo_flush;
   logic           deliver_done;
   logic           close_done;
   logic           conn_match;

   // Lowest-numbered port that saw a reset from the automation side
   always_comb begin
      link_reset      = |I_LINK_RESET;
      link_reset_port = '0;
      for (int i = NPORT - 1; i >= 0; i--) begin
         if (I_LINK_RESET[i]) begin
            link_reset_port = PW'(i);
         end
      end
   end

   assign conn_match   = (state_reg != SLCM_IDLE) && (I_REQ_CONN == conn_id_reg);
   // Receive finishes when its maximum is reached or the store runs dry after a character
   assign deliver_done = pend_reg && ((cnt_reg == max_reg) || (fifo_empty && cnt_reg != '0));
   assign fifo_rd      = pend_reg && !fifo_empty && (cnt_reg != max_reg) && !link_reset;
   // While open, incoming characters are stored; otherwise drained and dropped
   assign fifo_wr      = I_RX_VALID && (state_reg == SLCM_OPEN);
   assign fifo_flush   = link_reset;
   assign close_done   = (state_reg == SLCM_CLOSING) && !tx_valid_reg && fifo_empty
                         && !(pend_reg && cnt_reg != '0);
   assign O_SEND_READY = (state_reg == SLCM_OPEN) && (!tx_valid_reg || I_TX_READY);
   assign O_RX_READY   = (state_reg != SLCM_OPEN) || !fifo_full;

   slcm_rx_fifo #(
      .W     (8),
      .DEPTH (DEPTH)
   ) u_rx_fifo (
      .i_clk     (I_REF_CLK),
      .i_srst    (I_SRST),
      .i_flush   (fifo_flush),
      .i_wr_en   (fifo_wr),
      .i_wr_data (I_RX_DATA),
      .i_rd_en   (fifo_rd),
      .o_rd_data (fifo_data),
      .o_empty   (fifo_empty),
      .o_full    (fifo_full)
   );

   always_comb begin
      state_next      = state_reg;
      conn_id_next    = conn_id_reg;
      port_sel_next   = port_sel_reg;
      rsp_valid_next  = 1'b0;
      rsp_status_next = rsp_status_reg;
      rsp_conn_next   = rsp_conn_reg;
      connected_next  = 1'b0;
      closed_next     = 1'b0;
      pend_next       = pend_reg;
      buf_next        = buf_reg;
      max_next        = max_reg;
      cnt_next        = cnt_reg;
      received_next   = 1'b0;
      recvd_buf_next  = recvd_buf_reg;
      recvd_cnt_next  = recvd_cnt_reg;
      rd_valid_next   = 1'b0;
      rd_data_next    = rd_data_reg;
      rd_index_next   = rd_index_reg;
      tx_valid_next   = tx_valid_reg;
      tx_data_next    = tx_data_reg;
      rst_rcvd_next   = 1'b0;
      rst_port_next   = rst_port_reg;
      rst_hard_next   = rst_hard_reg;

      // Transmit holding stage; nothing enters it except send characters
      if (tx_valid_reg && I_TX_READY) begin
         tx_valid_next = 1'b0;
      end
      if (I_SEND_VALID && O_SEND_READY) begin
         tx_valid_next = 1'b1;
         tx_data_next  = I_SEND_DATA;
      end

      // Delivery of stored characters into the receive buffer
      if (fifo_rd) begin
         rd_valid_next = 1'b1;
         rd_data_next  = fifo_data;
         rd_index_next = cnt_reg;
         cnt_next      = cnt_reg + 1'b1;
      end else if (deliver_done) begin
         received_next  = 1'b1;
         recvd_buf_next = buf_reg;
         recvd_cnt_next = cnt_reg;
         pend_next      = 1'b0;
      end

      if (close_done) begin
         state_next  = SLCM_IDLE;
         closed_next = 1'b1;
         pend_next   = 1'b0;
      end

      if (I_REQ_VALID) begin
         rsp_valid_next  = 1'b1;
         rsp_conn_next   = conn_id_reg;
         rsp_status_next = SLCM_RSP_GOOD;
         unique case (I_REQ_OP)
            SLCM_OP_CONNECT, SLCM_OP_LISTEN: begin
               if (state_reg != SLCM_IDLE) begin
                  rsp_status_next = SLCM_RSP_PORT_IN_USE;
               end else begin
                  // Established at once; the link stays silent
                  state_next     = SLCM_OPEN;
                  conn_id_next   = conn_id_reg + 1'b1;
                  rsp_conn_next  = conn_id_reg + 1'b1;
                  port_sel_next  = I_REQ_PORT;
                  connected_next = 1'b1;
               end
            end
            SLCM_OP_RECEIVE: begin
               if (!conn_match) begin
                  rsp_status_next = SLCM_RSP_INVALID_CONN;
               end else if (pend_reg) begin
                  rsp_status_next = SLCM_RSP_RECV_PENDING;
               end else if (!close_done) begin
                  pend_next = 1'b1;
                  buf_next  = I_REQ_BUF;
                  max_next  = I_REQ_MAX;
                  cnt_next  = '0;
               end
            end
            SLCM_OP_CLOSE: begin
               if (!conn_match || state_reg != SLCM_OPEN) begin
                  rsp_status_next = SLCM_RSP_INVALID_CONN;
               end else begin
                  state_next = SLCM_CLOSING;
               end
            end
         endcase
      end

      // Reset from the automation side: logout or hard reset both drop the connection
      if (link_reset) begin
         state_next    = SLCM_IDLE;
         pend_next     = 1'b0;
         tx_valid_next = 1'b0;
         rd_valid_next = 1'b0;
         received_next = 1'b0;
         rst_rcvd_next = 1'b1;
         rst_port_next = link_reset_port;
         rst_hard_next = I_RESET_AS_HARD;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         state_reg      <= SLCM_IDLE;
         conn_id_reg    <= IDW'(SLCM_CONN_ID_RST);
         port_sel_reg   <= PW'(SLCM_PORT_SEL_RST);
         rsp_valid_reg  <= 1'b0;
         rsp_status_reg <= SLCM_RSP_GOOD;
         rsp_conn_reg   <= '0;
         connected_reg  <= 1'b0;
         closed_reg     <= 1'b0;
         pend_reg       <= 1'b0;
         buf_reg        <= '0;
         max_reg        <= '0;
         cnt_reg        <= '0;
         received_reg   <= 1'b0;
         recvd_buf_reg  <= '0;
         recvd_cnt_reg  <= '0;
         rd_valid_reg   <= 1'b0;
         rd_data_reg    <= 8'h00;
         rd_index_reg   <= '0;
         tx_valid_reg   <= 1'b0;
         tx_data_reg    <= 8'h00;
         rst_rcvd_reg   <= 1'b0;
         rst_port_reg   <= '0;
         rst_hard_reg   <= 1'b0;
      end else begin
         state_reg      <= state_next;
         conn_id_reg    <= conn_id_next;
         port_sel_reg   <= port_sel_next;
         rsp_valid_reg  <= rsp_valid_next;
         rsp_status_reg <= rsp_status_next;
         rsp_conn_reg   <= rsp_conn_next;
         connected_reg  <= connected_next;
         closed_reg     <= closed_next;
         pend_reg       <= pend_next;
         buf_reg        <= buf_next;
         max_reg        <= max_next;
         cnt_reg        <= cnt_next;
         received_reg   <= received_next;
         recvd_buf_reg  <= recvd_buf_next;
         recvd_cnt_reg  <= recvd_cnt_next;
         rd_valid_reg   <= rd_valid_next;
         rd_data_reg    <= rd_data_next;
         rd_index_reg   <= rd_index_next;
         tx_valid_reg   <= tx_valid_next;
         tx_data_reg    <= tx_data_next;
         rst_rcvd_reg   <= rst_rcvd_next;
         rst_port_reg   <= rst_port_next;
         rst_hard_reg   <= rst_hard_next;
      end
   end

   assign O_RSP_VALID   = rsp_valid_reg;
   assign O_RSP_STATUS  = rsp_status_reg;
   assign O_RSP_CONN    = rsp_conn_reg;
   assign O_CONNECTED   = connected_reg;
   assign O_IND_CONN    = conn_id_reg;
   assign O_CLOSED      = closed_reg;
   assign O_RECEIVED    = received_reg;
   assign O_RECVD_BUF   = recvd_buf_reg;
   assign O_RECVD_COUNT = recvd_cnt_reg;
   assign O_RD_VALID    = rd_valid_reg;
   assign O_RD_DATA     = rd_data_reg;
   assign O_RD_INDEX    = rd_index_reg;
   assign O_PORT_SEL    = port_sel_reg;
   assign O_TX_VALID    = tx_valid_reg;
   assign O_TX_DATA     = tx_data_reg;
   assign O_RESET_RCVD  = rst_rcvd_reg;
   assign O_RESET_PORT  = rst_port_reg;
   assign O_RESET_HARD  = rst_hard_reg;

endmodule // slcm_top

// [verif/slcm_assertions.sv]
// Port checker for the serial link connection manager
`timescale 1ns/10ps
module slcm_assertions
   import slcm_pkg::*;
#(
   parameter int NPORT = 2,
   parameter int IDW   = 4,
   parameter int BW    = 8,
   parameter int CW    = 8,
   parameter int PW    = 1
) (
   input wire logic             I_REF_CLK,
   input wire logic             I_SRST,
   input wire logic             I_REQ_VALID,
   input wire logic [1:0]       I_REQ_OP,
   input wire logic [BW-1:0]    I_REQ_BUF,
   input wire logic [CW-1:0]    I_REQ_MAX,
   input wire logic             O_RSP_VALID,
   input wire logic [2:0]       O_RSP_STATUS,
   input wire logic [IDW-1:0]   O_RSP_CONN,
   input wire logic             O_CONNECTED,
   input wire logic [IDW-1:0]   O_IND_CONN,
   input wire logic             O_CLOSED,
   input wire logic             O_RECEIVED,
   input wire logic [BW-1:0]    O_RECVD_BUF,
   input wire logic [CW-1:0]    O_RECVD_COUNT,
   input wire logic             O_RD_VALID,
   input wire logic [CW-1:0]    O_RD_INDEX,
   input wire logic             O_SEND_READY,
   input wire logic             O_TX_VALID,
   input wire logic             O_RX_READY,
   input wire logic [NPORT-1:0] I_LINK_RESET,
   input wire logic             I_RESET_AS_HARD,
   input wire logic             O_RESET_RCVD,
   input wire logic [PW-1:0]    O_RESET_PORT,
   input wire logic             O_RESET_HARD
);
   logic           open_next, open_reg, shut_next, shut_reg, good_rcv;
   logic [IDW-1:0] cid_next, cid_reg;
   logic [1:0]     op_next, op_reg;
   logic [BW-1:0]  buf_next, buf_reg, lbuf_next, lbuf_reg;
   logic [CW-1:0]  max_next, max_reg, lmax_next, lmax_reg;
   logic [PW-1:0]  low_next, low_reg;

   // Tracks connection, last closed state, accepted receive arguments
   always_comb begin
      open_next = !I_SRST && (open_reg || O_CONNECTED) && !O_CLOSED && !O_RESET_RCVD;
      shut_next = !I_SRST && (shut_reg || O_CLOSED) && !O_CONNECTED;
      cid_next = I_SRST ? '0 : (O_CONNECTED ? O_RSP_CONN : cid_reg);
      op_next = I_REQ_OP;
      buf_next = I_REQ_BUF;
      max_next = I_REQ_MAX;
      good_rcv = O_RSP_VALID && op_reg == SLCM_OP_RECEIVE && O_RSP_STATUS == SLCM_RSP_GOOD;
      lbuf_next = good_rcv ? buf_reg : lbuf_reg;
      lmax_next = good_rcv ? max_reg : lmax_reg;
      low_next = '0;
      for (int i = NPORT - 1; i >= 0; i--) begin
         if (I_LINK_RESET[i]) low_next = PW'(i);
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      open_reg <= open_next;
      shut_reg <= shut_next;
      cid_reg  <= cid_next;
      op_reg   <= op_next;
      buf_reg  <= buf_next;
      max_reg  <= max_next;
      lbuf_reg <= lbuf_next;
      lmax_reg <= lmax_next;
      low_reg  <= low_next;
   end

   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_SRST);

   property p_conn_rsp;
      O_CONNECTED |-> O_RSP_VALID && O_RSP_STATUS == SLCM_RSP_GOOD && O_RSP_CONN == O_IND_CONN;
   endproperty
   a_conn_rsp: assert property (p_conn_rsp) else $error("connected without good answer");
   property p_conn_quiet;
      O_CONNECTED |-> !O_TX_VALID && O_SEND_READY;
   endproperty
   a_conn_quiet: assert property (p_conn_quiet) else $error("connect sent data or not usable");
   property p_busy;
      I_REQ_VALID && I_REQ_OP <= SLCM_OP_LISTEN && open_next && I_LINK_RESET == '0
         |=> O_RSP_VALID && O_RSP_STATUS == SLCM_RSP_PORT_IN_USE && !O_CONNECTED;
   endproperty
   a_busy: assert property (p_busy) else $error("second connection not refused");
   property p_rd_max;
      O_RD_VALID |-> O_RD_INDEX < lmax_reg;
   endproperty
   a_rd_max: assert property (p_rd_max) else $error("character beyond receive maximum");
   property p_rcv_buf;
      O_RECEIVED |-> O_RECVD_BUF == lbuf_reg && O_RECVD_COUNT <= lmax_reg;
   endproperty
   a_rcv_buf: assert property (p_rcv_buf) else $error("received buffer or count wrong");
   property p_after_closed;
      shut_reg |-> !O_RECEIVED;
   endproperty
   a_after_closed: assert property (p_after_closed) else $error("received after closed");
   property p_closed_id;
      O_CLOSED |-> O_IND_CONN == cid_reg && !O_TX_VALID;
   endproperty
   a_closed_id: assert property (p_closed_id) else $error("closed id wrong or data left");
   property p_reset_ind;
      |I_LINK_RESET |=> O_RESET_RCVD && O_RESET_PORT == low_reg && O_RESET_HARD == $past(I_RESET_AS_HARD)
         && !O_SEND_READY;
   endproperty
   a_reset_ind: assert property (p_reset_ind) else $error("reset indication wrong");
   property p_idle_rst;
      $fell(I_SRST) |-> O_RX_READY && !O_SEND_READY && !O_RSP_VALID && !O_RECEIVED;
   endproperty
   a_idle_rst: assert property (p_idle_rst) else $error("not idle after reset");

   c_connect: cover property (O_CONNECTED);
   c_recv: cover property (O_RECEIVED && O_RECVD_COUNT > 0);
   c_closed: cover property (O_CLOSED);
   c_reset: cover property (O_RESET_RCVD && O_RESET_HARD);
endmodule // slcm_assertions

bind slcm_top slcm_assertions #(.NPORT(NPORT), .IDW(IDW), .BW(BW), .CW(CW), .PW(PW)) slcm_assertions_i (.*);

// [verif/slcm_link_peer.sv]
// Peer serial port model on the link side of the connection manager
`timescale 1ns/10ps
module slcm_link_peer (
   input  wire logic       i_clk,
   input  wire logic       i_slow,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   output logic            o_tx_ready = 1'b0,
   output logic            o_rx_valid = 1'b0,
   output logic      [7:0] o_rx_data = 8'h00,
   input  wire logic       i_rx_ready,
   output logic      [1:0] o_link_reset = 2'h0,
   output logic            o_hard = 1'b0
);
   logic [7:0] q[$];
   int         seed = 41822;

   // Each character, escapes included, is queued as one unit
   task push(input logic [7:0] d);
      q.push_back(d);
   endtask

   // The automation side picks the ports that carry the reset
   task send_reset(input logic [1:0] p, input logic h);
      @(posedge i_clk);
      o_link_reset <= p;
      o_hard <= h;
      @(posedge i_clk);
      o_link_reset <= 2'h0;
   endtask

   always @(posedge i_clk) begin
      o_tx_ready <= !i_slow || ($random(seed) % 3 == 0);
      if (!(o_rx_valid && !i_rx_ready)) begin
         if (q.size() > 0) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= q.pop_front();
         end else begin
            // Idle line keeps changing so a stale value is never mistaken for data
            o_rx_valid <= 1'b0;
            o_rx_data <= ~o_rx_data;
         end
      end
   end
endmodule // slcm_link_peer

// [verif/test_slcm_top.sv]
// Self-checking bench for the serial link connection manager
`timescale 1ns/10ps
module test_slcm_top;
   import slcm_pkg::*;
   logic        clk = 0, srst = 1, rv = 0, sv = 0, slow = 0, txr, rxv, rxr, hard;
   logic        rsp_v, con, cls, rcv, rdv, sr, txv, rr, rhard;
   logic [0:0]  pt = 0, psel, rport;
   logic [1:0]  op = 0, lrst;
   logic [2:0]  rsp_st;
   logic [3:0]  cn = 0, rsp_c, ind;
   logic [7:0]  bf = 0, mx = 0, sd = 0, rxd, rbuf, rcnt, rdd, rdi, txd, r;
   logic [7:0]  ch[3];
   logic [15:0] e;
   logic [15:0] q_rsp[$], q_rd[$], q_rcv[$], q_tx[$], q_cls[$], q_rst[$];
   int          failures = 0, n_checks = 0, seed = 41822, id = 0;

   slcm_top slcm_top_i (
      .I_REF_CLK(clk), .I_SRST(srst), .I_REQ_VALID(rv), .I_REQ_OP(op), .I_REQ_CONN(cn), .I_REQ_PORT(pt),
      .I_REQ_BUF(bf), .I_REQ_MAX(mx), .O_RSP_VALID(rsp_v), .O_RSP_STATUS(rsp_st), .O_RSP_CONN(rsp_c),
      .O_CONNECTED(con), .O_IND_CONN(ind), .O_CLOSED(cls), .O_RECEIVED(rcv), .O_RECVD_BUF(rbuf),
      .O_RECVD_COUNT(rcnt), .O_RD_VALID(rdv), .O_RD_DATA(rdd), .O_RD_INDEX(rdi), .I_SEND_VALID(sv),
      .I_SEND_DATA(sd), .O_SEND_READY(sr), .O_PORT_SEL(psel), .O_TX_VALID(txv), .O_TX_DATA(txd),
      .I_TX_READY(txr), .I_RX_VALID(rxv), .I_RX_DATA(rxd), .O_RX_READY(rxr), .I_LINK_RESET(lrst),
      .I_RESET_AS_HARD(hard), .O_RESET_RCVD(rr), .O_RESET_PORT(rport), .O_RESET_HARD(rhard));
   slcm_link_peer slcm_link_peer_i (.i_clk(clk), .i_slow(slow), .i_tx_valid(txv), .i_tx_data(txd),
      .o_tx_ready(txr), .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rxr), .o_link_reset(lrst), .o_hard(hard));

   always #2.5 clk = ~clk;

   task complete_run;
      if (failures == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task cmp(input string w, input logic [15:0] x, input logic [15:0] g);
      n_checks++;
      if (g !== x) begin
         failures++;
         $display("FAIL %s expected %h seen %h", w, x, g);
      end
   endtask

   // Request stays up into the next call, so calls run back to back
   task req(input logic [1:0] o, input logic [3:0] c, input logic [0:0] p, input logic [7:0] b, m,
            input logic [2:0] st);
      @(posedge clk);
      rv <= 1'b1;
      op <= o;
      cn <= c;
      pt <= p;
      bf <= b;
      mx <= m;
      if (st == SLCM_RSP_GOOD && o <= SLCM_OP_LISTEN) begin
         id++;
         q_rsp.push_back({8'h0, 1'b1, st, 4'(id)});
      end else q_rsp.push_back({9'h0, st, 4'h0});
   endtask

   task idle(input int n);
      repeat (n) begin
         @(posedge clk);
         rv <= 1'b0;
      end
   endtask

   task snd(input int n);
      for (int i = 0; i < n; i++) begin
         r = 8'($random(seed));
         sv <= 1'b1;
         sd <= r;
         q_tx.push_back({8'h0, r});
         do @(posedge clk); while (sr !== 1'b1);
      end
      sv <= 1'b0;
   endtask

   always @(posedge clk) begin
      if (!srst) begin
         if (rsp_v) begin
            e = q_rsp.pop_front();
            cmp("status", {13'h0, e[6:4]}, {13'h0, rsp_st});
            if (e[7] === 1'b1) cmp("conn", {12'h0, e[3:0]}, {12'h0, rsp_c});
            if (e[7] === 1'b1) cmp("connected", 16'h1, {15'h0, con});
         end
         if (rdv) cmp("character", q_rd.pop_front(), {rdi, rdd});
         if (rcv) cmp("received", q_rcv.pop_front(), {rbuf, rcnt});
         if (txv && txr) cmp("tx", q_tx.pop_front(), {8'h0, txd});
         if (cls) cmp("closed", q_cls.pop_front(), {12'h0, ind});
         if (rr) cmp("reset", q_rst.pop_front(), {14'h0, rport, rhard});
      end
   end

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      complete_run();
   end

   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      req(SLCM_OP_RECEIVE, 0, 0, 0, 8'h4, SLCM_RSP_INVALID_CONN);
      req(SLCM_OP_CLOSE, 0, 0, 0, 0, SLCM_RSP_INVALID_CONN);
      req(SLCM_OP_CONNECT, 4'h9, 1, 0, 0, SLCM_RSP_GOOD);
      req(SLCM_OP_LISTEN, 0, 0, 0, 0, SLCM_RSP_PORT_IN_USE);
      req(SLCM_OP_CONNECT, 0, 0, 0, 0, SLCM_RSP_PORT_IN_USE);
      idle(2);
      cmp("port", 16'h1, {15'h0, psel});
      slow <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         ch[i] = 8'($random(seed));
         slcm_link_peer_i.push(ch[i]);
      end
      snd(5);
      idle(6);
      r = 8'($random(seed));
      req(SLCM_OP_RECEIVE, 4'(id), 0, r, 8'h2, SLCM_RSP_GOOD);
      req(SLCM_OP_RECEIVE, 4'(id), 0, 0, 8'h5, SLCM_RSP_RECV_PENDING);
      q_rd.push_back({8'h0, ch[0]});
      q_rd.push_back({8'h1, ch[1]});
      q_rcv.push_back({r, 8'h2});
      idle(6);
      r = 8'($random(seed));
      req(SLCM_OP_RECEIVE, 4'(id), 0, r, 8'h5, SLCM_RSP_GOOD);
      q_rd.push_back({8'h0, ch[2]});
      q_rcv.push_back({r, 8'h1});
      idle(6);
      for (int i = 0; i < 2; i++) begin
         ch[i] = 8'($random(seed));
         slcm_link_peer_i.push(ch[i]);
      end
      idle(6);
      snd(3);
      req(SLCM_OP_CLOSE, 4'(id + 1), 0, 0, 0, SLCM_RSP_INVALID_CONN);
      req(SLCM_OP_CLOSE, 4'(id), 0, 0, 0, SLCM_RSP_GOOD);
      req(SLCM_OP_CLOSE, 4'(id), 0, 0, 0, SLCM_RSP_INVALID_CONN);
      q_cls.push_back({12'h0, 4'(id)});
      idle(2);
      cmp("send ready", 16'h0, {15'h0, sr});
      slcm_link_peer_i.push(8'h5a);
      r = 8'($random(seed));
      req(SLCM_OP_RECEIVE, 4'(id), 0, r, 8'h8, SLCM_RSP_GOOD);
      q_rd.push_back({8'h0, ch[0]});
      q_rd.push_back({8'h1, ch[1]});
      q_rcv.push_back({r, 8'h2});
      idle(40);
      req(SLCM_OP_RECEIVE, 4'(id), 0, 0, 8'h4, SLCM_RSP_INVALID_CONN);
      slow <= 1'b0;
      req(SLCM_OP_LISTEN, 0, 0, 0, 0, SLCM_RSP_GOOD);
      idle(2);
      cmp("port", 16'h0, {15'h0, psel});
      for (int k = 1; k < 4; k++) begin
         slcm_link_peer_i.send_reset(2'(k), k[0]);
         q_rst.push_back({14'h0, !k[0], k[0]});
         idle(3);
         req(SLCM_OP_CONNECT, 0, 1'(k >> 1), 0, 0, SLCM_RSP_GOOD);
         idle(2);
      end
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      id = 0;
      req(SLCM_OP_CONNECT, 0, 0, 0, 0, SLCM_RSP_GOOD);
      idle(10);
      cmp("pending", 16'h0, 16'(q_rsp.size() + q_rd.size() + q_rcv.size() + q_tx.size() + q_cls.size()
          + q_rst.size()));
      complete_run();
   end
endmodule // test_slcm_top
